// [src/uart_ctl2.sv]
// Purpose: Second control register of a serial port with pin ownership logic
// Assumes: One clock, async active-low reset, flags come from same-clock logic
// Notes:   Shifter reports busy and pending traffic; this block only steers
module uart_ctl2 (
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 rstn,
   // Register port
   input  wire uart_ctl2_pkg::reg_req_s req,
   output logic [7:0]                rdata,
   // Flags and shifter status
   input  wire uart_ctl2_pkg::uart_flags_s flags,
   input  wire logic                 tx_busy,
   // Transmitter and receiver controls
   output logic                      tx_run,
   output logic                      queue_idle,
   output logic                      tx_irq,
   output logic                      rx_irq,
   output logic                      rx_run,
   // Pin ownership and interrupt
   output logic                      txd_owned,
   output logic                      txd_oe,
   output logic                      rxd_owned,
   output logic                      irq
);

   typedef struct packed {
      logic [7:0]              ctrl2_r;
      logic [7:0]              link_r;
      logic [7:0]              stat_r;
      logic [7:0]              mask_r;
      logic [7:0]              rdata_r;
      uart_ctl2_pkg::pin_own_e own_r;
      logic                    off_seen_r;
      logic                    qidle_r;
      logic                    tx_irq_r;
      logic                    rx_irq_r;
      logic                    irq_r;
      logic                    txd_oe_r;
      logic                    owned_r;
   } state_s;

   state_s s_r;
   state_s s_nxt;

   // Bit select helper used for many fields
   function automatic logic bit_of(input logic [7:0] v, input int idx);
      bit_of = v[idx[2:0]];
   endfunction

   // Next-state logic for the whole block
   always_comb begin
      logic tx_on;
      logic loopback_select;
      logic rx_source_select;
      logic wr_c2;
      logic [7:0] ev;
      tx_on = 1'b0;
      loopback_select = 1'b0;
      rx_source_select  = 1'b0;
      wr_c2 = 1'b0;
      ev    = uart_ctl2_pkg::ZERO8;
      s_nxt = s_r;
      wr_c2 = req.wr && req.addr == uart_ctl2_pkg::ADDR_CTRL2;

      // Writes accepted regardless of shifter state
      if (wr_c2) begin
         s_nxt.ctrl2_r = req.wdata & uart_ctl2_pkg::CTRL2_WMASK;
      end
      if (req.wr && req.addr == uart_ctl2_pkg::ADDR_LINK_CFG) begin
         s_nxt.link_r = req.wdata & uart_ctl2_pkg::LINK_WMASK;
      end
      if (req.wr && req.addr == uart_ctl2_pkg::ADDR_IRQ_MASK) begin
         s_nxt.mask_r = req.wdata & uart_ctl2_pkg::EV_WMASK;
      end

      tx_on = bit_of(s_nxt.ctrl2_r, uart_ctl2_pkg::BIT_TX_ON);
      loopback_select = bit_of(s_nxt.link_r, uart_ctl2_pkg::BIT_LOOPBACK);
      rx_source_select  = bit_of(s_nxt.link_r, uart_ctl2_pkg::BIT_RX_SOURCE);

      // Off then on while busy queues one idle character
      if (wr_c2 && !bit_of(req.wdata, uart_ctl2_pkg::BIT_TX_ON) && tx_busy) begin
         s_nxt.off_seen_r = 1'b1;
      end
      s_nxt.qidle_r = 1'b0;
      if (s_r.off_seen_r && wr_c2 && bit_of(req.wdata, uart_ctl2_pkg::BIT_TX_ON)) begin
         s_nxt.qidle_r    = 1'b1;
         s_nxt.off_seen_r = 1'b0;
         ev[uart_ctl2_pkg::EV_QUEUED_IDLE] = 1'b1;
      end else if (!tx_busy && !tx_on) begin
         s_nxt.off_seen_r = 1'b0;
      end

      // Pin ownership; drain keeps the pin until shifter empties
      unique case (s_r.own_r)
         uart_ctl2_pkg::PIN_PORT: begin
            if (tx_on) begin
               s_nxt.own_r = uart_ctl2_pkg::PIN_OWNED;
            end
         end
         uart_ctl2_pkg::PIN_OWNED: begin
            if (!tx_on) begin
               s_nxt.own_r = tx_busy ? uart_ctl2_pkg::PIN_DRAIN
                                     : uart_ctl2_pkg::PIN_PORT;
               ev[uart_ctl2_pkg::EV_PIN_RELEASE] = !tx_busy;
            end
         end
         uart_ctl2_pkg::PIN_DRAIN: begin
            if (tx_on) begin
               s_nxt.own_r = uart_ctl2_pkg::PIN_OWNED;
            end else if (!tx_busy && !s_r.qidle_r) begin
               s_nxt.own_r = uart_ctl2_pkg::PIN_PORT;
               ev[uart_ctl2_pkg::EV_PIN_RELEASE] = 1'b1;
            end
         end
         default: s_nxt.own_r = uart_ctl2_pkg::PIN_PORT;
      endcase

      // Loopback with internal source stops driving the pin; ownership is kept
      if (s_nxt.own_r == uart_ctl2_pkg::PIN_PORT || (loopback_select && !rx_source_select)) begin
         s_nxt.txd_oe_r = 1'b0;
      end else if (loopback_select && rx_source_select) begin
         s_nxt.txd_oe_r = bit_of(s_nxt.link_r, uart_ctl2_pkg::BIT_WIRE_DIR);
      end else begin
         s_nxt.txd_oe_r = 1'b1;
      end

      // Level requests, held while flag and enable hold
      s_nxt.tx_irq_r =
         (bit_of(s_r.ctrl2_r, uart_ctl2_pkg::BIT_TX_EMPTY_IE) && flags.tx_buffer_empty_flag)
         || (bit_of(s_r.ctrl2_r, uart_ctl2_pkg::BIT_TX_DONE_IE) && flags.tx_complete_flag);
      s_nxt.rx_irq_r =
         (bit_of(s_r.ctrl2_r, uart_ctl2_pkg::BIT_RX_FULL_IE) && flags.rx_data_full_flag)
         || (bit_of(s_r.ctrl2_r, uart_ctl2_pkg::BIT_IDLE_IE) && flags.idle_line_flag);
      ev[uart_ctl2_pkg::EV_TX_REQ] = s_nxt.tx_irq_r && !s_r.tx_irq_r;
      ev[uart_ctl2_pkg::EV_RX_REQ] = s_nxt.rx_irq_r && !s_r.rx_irq_r;

      // Sticky status: write one clears, a new event wins
      if (req.wr && req.addr == uart_ctl2_pkg::ADDR_IRQ_STAT) begin
         s_nxt.stat_r = s_r.stat_r & ~req.wdata;
      end
      s_nxt.stat_r = s_nxt.stat_r | ev;
      s_nxt.irq_r  = |(s_nxt.stat_r & s_nxt.mask_r);

      // Read data in the following cycle; unmapped reads zero
      s_nxt.rdata_r = uart_ctl2_pkg::ZERO8;
      if (req.rd) begin
         unique case (req.addr)
            uart_ctl2_pkg::ADDR_CTRL2:    s_nxt.rdata_r = s_r.ctrl2_r;
            uart_ctl2_pkg::ADDR_IRQ_STAT: s_nxt.rdata_r = s_r.stat_r;
            uart_ctl2_pkg::ADDR_IRQ_MASK: s_nxt.rdata_r = s_r.mask_r;
            uart_ctl2_pkg::ADDR_LINK_CFG: s_nxt.rdata_r = s_r.link_r;
            uart_ctl2_pkg::ADDR_PIN_STAT:
               s_nxt.rdata_r = {4'h0, s_r.qidle_r, s_r.txd_oe_r, 2'(s_r.own_r)};
            default:                      s_nxt.rdata_r = uart_ctl2_pkg::ZERO8;
         endcase
      end
      // Registered copy so pin outputs come straight from a flop
      s_nxt.owned_r = s_nxt.own_r != uart_ctl2_pkg::PIN_PORT;
   end

   // State register
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_r          <= '0;
         s_r.ctrl2_r  <= uart_ctl2_pkg::CTRL2_RESET;
         s_r.link_r   <= uart_ctl2_pkg::LINK_RESET;
         s_r.own_r    <= uart_ctl2_pkg::PIN_PORT;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from flops
   assign rdata      = s_r.rdata_r;
   assign tx_run     = s_r.owned_r;
   assign queue_idle = s_r.qidle_r;
   assign tx_irq     = s_r.tx_irq_r;
   assign rx_irq     = s_r.rx_irq_r;
   assign rx_run     = s_r.ctrl2_r[uart_ctl2_pkg::BIT_RX_ON];
   assign rxd_owned  = s_r.ctrl2_r[uart_ctl2_pkg::BIT_RX_ON];
   assign txd_owned  = s_r.owned_r;
   assign txd_oe     = s_r.txd_oe_r;
   assign irq        = s_r.irq_r;

   // Checks
   property p_tx_empty_req;
      @(posedge clock) disable iff (!rstn)
      (s_r.ctrl2_r[uart_ctl2_pkg::BIT_TX_EMPTY_IE] && flags.tx_buffer_empty_flag) |=> tx_irq;
   endproperty
   a_tx_empty_req: assert property (p_tx_empty_req) else $error("tx empty request missing");

   property p_tx_done_req;
      @(posedge clock) disable iff (!rstn)
      (s_r.ctrl2_r[uart_ctl2_pkg::BIT_TX_DONE_IE] && flags.tx_complete_flag) |=> tx_irq;
   endproperty
   a_tx_done_req: assert property (p_tx_done_req) else $error("tx done request missing");

   property p_rx_full_req;
      @(posedge clock) disable iff (!rstn)
      (s_r.ctrl2_r[uart_ctl2_pkg::BIT_RX_FULL_IE] && flags.rx_data_full_flag) |=> rx_irq;
   endproperty
   a_rx_full_req: assert property (p_rx_full_req) else $error("rx full request missing");

   property p_idle_req;
      @(posedge clock) disable iff (!rstn)
      (s_r.ctrl2_r[uart_ctl2_pkg::BIT_IDLE_IE] && flags.idle_line_flag) |=> rx_irq;
   endproperty
   a_idle_req: assert property (p_idle_req) else $error("idle request missing");

   property p_tx_quiet;
      @(posedge clock) disable iff (!rstn)
      (!s_r.ctrl2_r[uart_ctl2_pkg::BIT_TX_EMPTY_IE] && !s_r.ctrl2_r[uart_ctl2_pkg::BIT_TX_DONE_IE])
      |=> !tx_irq;
   endproperty
   a_tx_quiet: assert property (p_tx_quiet) else $error("tx request while disabled");

   property p_write_read;
      @(posedge clock) disable iff (!rstn)
      (req.wr && req.addr == uart_ctl2_pkg::ADDR_CTRL2) ##1
      (req.rd && req.addr == uart_ctl2_pkg::ADDR_CTRL2 && !req.wr)
      |=> rdata == ($past(req.wdata, 2) & uart_ctl2_pkg::CTRL2_WMASK);
   endproperty
   a_write_read: assert property (p_write_read) else $error("readback mismatch");

   property p_drain;
      @(posedge clock) disable iff (!rstn)
      (txd_owned && !s_r.ctrl2_r[uart_ctl2_pkg::BIT_TX_ON] && tx_busy) |=> txd_owned;
   endproperty
   a_drain: assert property (p_drain) else $error("pin released while busy");

   property p_loop_release;
      @(posedge clock) disable iff (!rstn)
      (s_r.link_r[uart_ctl2_pkg::BIT_LOOPBACK] && !s_r.link_r[uart_ctl2_pkg::BIT_RX_SOURCE])
      |-> !txd_oe;
   endproperty
   a_loop_release: assert property (p_loop_release) else $error("pin driven in loopback");

   property p_off_idle;
      @(posedge clock) disable iff (!rstn)
      (!s_r.ctrl2_r[uart_ctl2_pkg::BIT_TX_ON] && s_r.own_r != uart_ctl2_pkg::PIN_DRAIN)
      |-> !tx_run;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("transmitter runs while off");

   property p_rx_pin;
      @(posedge clock) disable iff (!rstn)
      (req.wr && req.addr == uart_ctl2_pkg::ADDR_CTRL2)
      |=> rxd_owned == $past(req.wdata[uart_ctl2_pkg::BIT_RX_ON]);
   endproperty
   a_rx_pin: assert property (p_rx_pin) else $error("rx pin ownership wrong");

   // Receive pin only moves on a write
   property p_rx_hold;
      @(posedge clock) disable iff (!rstn)
      !(req.wr && req.addr == uart_ctl2_pkg::ADDR_CTRL2) |=> $stable(rxd_owned);
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("rx pin moved without write");

   // Enabling the transmitter takes the pin at once
   property p_tx_on_owns;
      @(posedge clock) disable iff (!rstn)
      (req.wr && req.addr == uart_ctl2_pkg::ADDR_CTRL2 && req.wdata[uart_ctl2_pkg::BIT_TX_ON])
      |=> (tx_run && txd_owned);
   endproperty
   a_tx_on_owns: assert property (p_tx_on_owns) else $error("pin not taken");

   // Pin direction in port, normal and single-wire setups
   property p_port_quiet;
      @(posedge clock) disable iff (!rstn)
      !txd_owned |-> !txd_oe;
   endproperty
   a_port_quiet: assert property (p_port_quiet) else $error("unowned pin driven");

   property p_tx_pin_drive;
      @(posedge clock) disable iff (!rstn)
      (txd_owned && !s_r.link_r[uart_ctl2_pkg::BIT_LOOPBACK]) |-> txd_oe;
   endproperty
   a_tx_pin_drive: assert property (p_tx_pin_drive) else $error("pin not driven");

   property p_wire_dir;
      @(posedge clock) disable iff (!rstn)
      (txd_owned && s_r.link_r[uart_ctl2_pkg::BIT_LOOPBACK]
       && s_r.link_r[uart_ctl2_pkg::BIT_RX_SOURCE])
      |-> txd_oe == s_r.link_r[uart_ctl2_pkg::BIT_WIRE_DIR];
   endproperty
   a_wire_dir: assert property (p_wire_dir) else $error("single-wire direction wrong");

   // Queued idle is one pulse, caused by an enabling write
   property p_queue_pulse;
      @(posedge clock) disable iff (!rstn)
      queue_idle |=> !queue_idle;
   endproperty
   a_queue_pulse: assert property (p_queue_pulse) else $error("idle pulse too long");

   property p_queue_cause;
      @(posedge clock) disable iff (!rstn)
      queue_idle |-> ($past(req.wr) && $past(req.addr) == uart_ctl2_pkg::ADDR_CTRL2 && tx_run);
   endproperty
   a_queue_cause: assert property (p_queue_cause) else $error("idle without write");

   // Pin goes back to the port once traffic is done
   property p_release;
      @(posedge clock) disable iff (!rstn)
      (txd_owned && !s_r.ctrl2_r[uart_ctl2_pkg::BIT_TX_ON] && !tx_busy
       && !queue_idle && !req.wr) |=> !txd_owned;
   endproperty
   a_release: assert property (p_release) else $error("pin kept after traffic");

   // Requests only follow their own flags and enables
   property p_tx_cause;
      @(posedge clock) disable iff (!rstn)
      tx_irq |-> ($past(flags.tx_buffer_empty_flag) || $past(flags.tx_complete_flag));
   endproperty
   a_tx_cause: assert property (p_tx_cause) else $error("tx request without flag");

   property p_rx_quiet;
      @(posedge clock) disable iff (!rstn)
      (!s_r.ctrl2_r[uart_ctl2_pkg::BIT_RX_FULL_IE] && !s_r.ctrl2_r[uart_ctl2_pkg::BIT_IDLE_IE])
      |=> !rx_irq;
   endproperty
   a_rx_quiet: assert property (p_rx_quiet) else $error("rx request while disabled");

   // Main scenarios worth seeing
   c_queue_idle: cover property (@(posedge clock) disable iff (!rstn) queue_idle);
   c_drain: cover property (@(posedge clock) disable iff (!rstn)
      s_r.own_r == uart_ctl2_pkg::PIN_DRAIN ##1 s_r.own_r == uart_ctl2_pkg::PIN_PORT);
   c_irq: cover property (@(posedge clock) disable iff (!rstn) irq);
   c_single_wire: cover property (@(posedge clock) disable iff (!rstn)
      txd_oe && s_r.link_r[uart_ctl2_pkg::BIT_RX_SOURCE]);
   c_write_read: cover property (@(posedge clock) disable iff (!rstn)
      (req.wr && req.addr == uart_ctl2_pkg::ADDR_CTRL2) ##1 req.rd);

endmodule

// [src/uart_ctl2_pkg.sv]
// Purpose: Shared constants and carriers for the second serial control register
// Assumes: 8-bit register port, single 40 MHz clock
// Notes:   Offsets of the register window are local choices
package uart_ctl2_pkg;

   // Register map (byte addresses on the plain port)
   localparam logic [3:0] ADDR_CTRL2     = 4'h0;
   localparam logic [3:0] ADDR_IRQ_STAT  = 4'h1;
   localparam logic [3:0] ADDR_IRQ_MASK  = 4'h2;
   localparam logic [3:0] ADDR_LINK_CFG  = 4'h3;
   localparam logic [3:0] ADDR_PIN_STAT  = 4'h4;

   // Control register two field positions
   localparam int BIT_TX_EMPTY_IE = 7;
   localparam int BIT_TX_DONE_IE  = 6;
   localparam int BIT_RX_FULL_IE  = 5;
   localparam int BIT_IDLE_IE     = 4;
   localparam int BIT_TX_ON       = 3;
   localparam int BIT_RX_ON       = 2;
   localparam logic [7:0] CTRL2_RESET = 8'h00;
   localparam logic [7:0] CTRL2_WMASK = 8'hfc; // Bits 1..0 live elsewhere

   // Link configuration field positions
   localparam int BIT_LOOPBACK   = 0;
   localparam int BIT_RX_SOURCE  = 1;
   localparam int BIT_WIRE_DIR   = 2;
   localparam logic [7:0] LINK_RESET = 8'h00;
   localparam logic [7:0] LINK_WMASK = 8'h07;

   // Sticky event bits
   localparam int EV_QUEUED_IDLE = 0;
   localparam int EV_PIN_RELEASE = 1;
   localparam int EV_TX_REQ      = 2;
   localparam int EV_RX_REQ      = 3;
   localparam logic [7:0] EV_WMASK = 8'h0f;
   localparam logic [7:0] ZERO8    = 8'h00;

   // Pin ownership states of the transmit pin
   typedef enum logic [1:0] {
      PIN_PORT  = 2'b00,
      PIN_OWNED = 2'b01,
      PIN_DRAIN = 2'b10
   } pin_own_e;

   // Flags from the shifter side
   typedef struct packed {
      logic tx_buffer_empty_flag;
      logic tx_complete_flag;
      logic rx_data_full_flag;
      logic idle_line_flag;
   } uart_flags_s;

   // Register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_s;

endpackage

// [tb/uart_ctl2_tb_top.sv]
// Purpose: Self-checking bench for the second serial control register
// Assumes: 40 MHz clock, 20-cycle reset, register reads answer next cycle
// Notes:   Each scenario is a task that judges its own results
module uart_ctl2_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic                       clock, rstn, start;
   uart_ctl2_pkg::reg_req_s    req;
   uart_ctl2_pkg::uart_flags_s flags;
   logic [7:0]                 rdata, rv;
   logic [3:0]                 flag_drive;
   logic                       tx_busy, tx_run, queue_idle, tx_irq, rx_irq, rx_run;
   logic                       txd_owned, txd_oe, rxd_owned, irq;
   int                         err_count, checks;

   uart_ctl2 i_uart_ctl2 (.clock(clock), .rstn(rstn), .req(req), .rdata(rdata),
      .flags(flags), .tx_busy(tx_busy), .tx_run(tx_run), .queue_idle(queue_idle),
      .tx_irq(tx_irq), .rx_irq(rx_irq), .rx_run(rx_run), .txd_owned(txd_owned),
      .txd_oe(txd_oe), .rxd_owned(rxd_owned), .irq(irq));
   uart_node_model i_uart_node_model (.clock(clock), .rstn(rstn), .tx_run(tx_run),
      .queue_idle(queue_idle), .start(start), .flag_drive(flag_drive), .flags(flags),
      .tx_busy(tx_busy));

   // Clock at 25 ns
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end

   task automatic complete_run();
      $display("Mismatches %0d, comparisons %0d", err_count, checks);
      if (err_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One-cycle strobes; returns mid-cycle after the taking edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      req.addr  <= a;
      req.wdata <= d;
      req.wr    <= 1'b1;
      @(posedge clock);
      req.wr    <= 1'b0;
      @(negedge clock);
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      req.addr <= a;
      req.rd   <= 1'b1;
      @(posedge clock);
      req.rd   <= 1'b0;
      @(negedge clock);
      d = rdata;
   endtask

   // Reset values, read-back, unmapped place
   task automatic t_regs();
      check({tx_run, txd_owned, txd_oe, rx_run, rxd_owned, irq, tx_irq, rx_irq}, 8'h00);
      rd(4'h0, rv);
      check(rv, 8'h00);
      wr(4'h0, 8'hff);
      rd(4'h0, rv);
      check(rv, 8'hfc);
      rd(4'hf, rv);
      check(rv, 8'h00);
      // Write then read with no gap
      @(posedge clock);
      req.addr  <= uart_ctl2_pkg::ADDR_CTRL2;
      req.wdata <= 8'ha5;
      req.wr    <= 1'b1;
      @(posedge clock);
      req.wr    <= 1'b0;
      req.rd    <= 1'b1;
      @(posedge clock);
      req.rd    <= 1'b0;
      @(negedge clock);
      check(rdata, 8'ha4);
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h0f);
   endtask

   // Each enable against its own flag, then the enable cleared again
   task automatic t_irq();
      for (int i = 0; i < 4; i++) begin
         @(posedge clock) flag_drive <= 4'h1 << i;
         wr(4'h0, 8'h10 << i);
         @(negedge clock);
         check({6'h00, tx_irq, rx_irq}, (i >= 2) ? 8'h02 : 8'h01);
         wr(4'h0, 8'h00);
         @(negedge clock);
         check({6'h00, tx_irq, rx_irq}, 8'h00);
      end
      @(posedge clock) flag_drive <= 4'h0;
      rd(4'h1, rv);
      check(rv, 8'h0c);
      wr(4'h2, 8'h04);
      @(negedge clock);
      check({7'h00, irq}, 8'h01);
      wr(4'h1, 8'h04);
      @(negedge clock);
      check({7'h00, irq}, 8'h00);
      wr(4'h1, 8'h08);
      wr(4'h2, 8'h00);
   endtask

   // Pin ownership in normal, loop and single-wire setups
   task automatic t_pins();
      logic [7:0] link[4] = '{8'h00, 8'h01, 8'h03, 8'h07};
      logic       oe[4]   = '{1'b1, 1'b0, 1'b0, 1'b1};
      wr(4'h0, 8'h0c);
      check({5'h00, tx_run, txd_owned, txd_oe}, 8'h07);
      for (int i = 0; i < 4; i++) begin
         wr(4'h3, link[i]);
         check({5'h00, rx_run, rxd_owned, txd_oe}, {5'h00, 2'b11, oe[i]});
      end
      wr(4'h3, 8'h00);
   endtask

   // Queued idle mid-character, then disable with traffic pending
   task automatic t_drain();
      int n;
      @(posedge clock) start <= 1'b1;
      @(posedge clock) start <= 1'b0;
      wr(4'h0, 8'h00);
      check({7'h00, txd_owned}, 8'h01);
      wr(4'h0, 8'h08);
      check({7'h00, queue_idle}, 8'h01);
      rd(4'h1, rv);
      check(rv & 8'h01, 8'h01);
      wr(4'h0, 8'h00);
      check({6'h00, txd_owned, rx_run}, 8'h02);
      n = 0;
      while (tx_busy === 1'b1 && n < 64) begin
         @(negedge clock);
         n++;
      end
      n = 0;
      while (txd_owned !== 1'b0 && n < 4) begin
         @(negedge clock);
         n++;
      end
      if (tx_busy !== 1'b0 || txd_owned !== 1'b0) begin
         err_count++;
         complete_run();
      end
      check({7'h00, txd_owned}, 8'h00);
   endtask

   // Main sequence
   initial begin
      rstn = 1'b0;
      start = 1'b0;
      flag_drive = 4'h0;
      req = '0;
      err_count = 0;
      checks = 0;
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      @(negedge clock);
      t_regs();
      t_irq();
      t_pins();
      t_drain();
      complete_run();
   end
endmodule

// [tb/uart_node_model.sv]
// Purpose: Shifter and line model on the far side of the control register
// Assumes: Same clock as the register block
// Notes:   Flag levels come straight from the bench; busy time is one character per start or queued idle
module uart_node_model #(
   parameter int CHAR_CYCLES = 12
) (
   // Clock and reset
   input  wire logic                       clock,
   input  wire logic                       rstn,
   // Controls from the register block
   input  wire logic                       tx_run,
   input  wire logic                       queue_idle,
   // Bench stimulus
   input  wire logic                       start,
   input  wire logic [3:0]                 flag_drive,
   // Status back to the register block
   output uart_ctl2_pkg::uart_flags_s      flags,
   output logic                            tx_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt;

   // Character timer; idle character stacks on pending data
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt <= 0;
      end else if (start && tx_run) begin
         cnt <= CHAR_CYCLES;
      end else if (queue_idle) begin
         cnt <= cnt + CHAR_CYCLES;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end
   assign tx_busy = (cnt != 0);
   assign flags   = flag_drive;
endmodule
